//--- rtl/adto_defs.svh
`ifndef ADTO_DEFS_SVH
`define ADTO_DEFS_SVH

// register indices; the byte address is four times the index
`define ADTO_IDX_THRESHOLD 8'h68
`define ADTO_IDX_EDGES_ONE_TWO 8'h69
`define ADTO_IDX_EDGES_THREE_FOUR 8'h6a
`define ADTO_IDX_SENSE_RANGE 8'h70
`define ADTO_IDX_STATUS 8'h71

// field positions inside the edge, threshold, range and status bytes
`define ADTO_UPPER_SIGN_BIT 7
`define ADTO_UPPER_SHIFT_HI 6
`define ADTO_UPPER_SHIFT_LO 4
`define ADTO_LOWER_SIGN_BIT 3
`define ADTO_LOWER_SHIFT_HI 2
`define ADTO_LOWER_SHIFT_LO 0
`define ADTO_THRESH_HI 2
`define ADTO_THRESH_LO 0
`define ADTO_RANGE_HI 1
`define ADTO_RANGE_LO 0
`define ADTO_STATUS_ACTIVE_BIT 0

// reset values
`define ADTO_RST_BYTE 8'h00
`define ADTO_RST_RANGE 2'h0

// timing: offset step and clock period in ns, cycles derived
`define ADTO_STEP_NS 5
`define ADTO_CLK_NS 5
`define ADTO_STEP_CYC (`ADTO_STEP_NS / `ADTO_CLK_NS)
`define ADTO_MAX_CODE 7
`define ADTO_BASE_CYC (`ADTO_MAX_CODE * `ADTO_STEP_CYC)
`define ADTO_LINE_DEPTH (2 * `ADTO_BASE_CYC + 1)

// threshold step per code in units of 0.1 mV for each sense range
`define ADTO_LSB_RANGE_LOW 8'h27
`define ADTO_LSB_RANGE_MID 8'h4e
`define ADTO_LSB_RANGE_HIGH 8'h9c

`endif

//--- rtl/adto_pkg.sv
package adto_pkg;
   typedef logic [2:0] adto_shift_t;   // 3-bit offset code
   typedef logic [7:0] adto_byte_t;    // one register byte
   typedef logic [11:0] adto_sense_t;  // sensed current, 0.1 mV units
   // nominal sense range selection
   typedef enum logic [1:0] {
      ADTO_RANGE_LOW = 2'h0,
      ADTO_RANGE_MID = 2'h1,
      ADTO_RANGE_HIGH = 2'h2,
      ADTO_RANGE_SPARE = 2'h3
   } adto_range_e;
endpackage

//--- rtl/adto_edge_if.sv
// carries one edge's settings down and its shifted edge back up
interface adto_edge_if;
   import adto_pkg::*;
   logic sign;           // 1 = advance, 0 = delay
   adto_shift_t shift;   // offset code
   logic apply;          // offsets enabled by the current gate
   logic nominal;        // nominal edge pulse
   logic shifted;        // edge pulse after shifting
   modport ctrl (output sign, output shift, output apply, output nominal, input shifted);
   modport shifter (input sign, input shift, input apply, input nominal, output shifted);
endinterface

//--- rtl/adto_edge_shift.sv
`include "adto_defs.svh"

// moves one edge pulse by a signed number of 5 ns steps
module adto_edge_shift
   import adto_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   adto_edge_if.shifter edge_io
);
   logic [`ADTO_LINE_DEPTH-1:0] line;   // pulse delay line
   logic [3:0] step_cyc;                // code converted to cycles
   logic [3:0] tap;                     // selected line position
   logic shifted;                       // registered output pulse

   // each code step is one 5 ns step of the clock [R2] [R3] [R4] [R5]
   assign step_cyc = 4'(edge_io.shift * `ADTO_STEP_CYC);
   // advance cannot be causal, so every edge carries a fixed base delay and
   // a negative offset takes steps off it; changing settings while a pulse
   // is in flight may drop or double that one pulse [R1] [R8] [R6]
   assign tap = !edge_io.apply ? 4'(`ADTO_BASE_CYC) :
                edge_io.sign ? 4'(`ADTO_BASE_CYC) - step_cyc :
                4'(`ADTO_BASE_CYC) + step_cyc;
   assign edge_io.shifted = shifted;

   // delay line and tap register
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         line <= '0;
         shifted <= 1'b0;
      end else begin
         line <= {line[`ADTO_LINE_DEPTH-2:0], edge_io.nominal};
         shifted <= line[tap];
      end
   end

   delay_max_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R8]
      edge_io.nominal && edge_io.apply && !edge_io.sign && edge_io.shift == 3'h7 |-> ##16 shifted)
      else $error("positive offset did not delay edge by seven steps");
   advance_max_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R1]
      edge_io.nominal && edge_io.apply && edge_io.sign && edge_io.shift == 3'h7 |-> ##2 shifted)
      else $error("negative offset did not advance edge by seven steps");
   nominal_keep_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R6]
      edge_io.nominal && !edge_io.apply |-> ##9 shifted)
      else $error("edge left nominal timing while offsets were off");
   one_step_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R2]
      edge_io.nominal && edge_io.apply && !edge_io.sign && edge_io.shift == 3'h1 |-> ##10 shifted)
      else $error("code one did not give a single 5 ns step");
endmodule

//--- rtl/adto_top.sv
// Design decision made here: register access over Avalon-MM.
`include "adto_defs.svh"

// Behaviour
// R1: sign bit 0 delays, 1 advances
// R2: edge one code bits 6:4, 5 ns steps
// R3: edge two code bits 2:0, 5 ns steps
// R4: edge three code bits 6:4, 5 ns steps
// R5: edge four code bits 2:0, 5 ns steps
// R6: offsets only while sense below threshold
// R7: 3-bit threshold code scaled by sense range
// R8: positive delays, negative advances, 5 ns quantum
module adto_top
   import adto_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [11:0] secondary_current_sense_in,
   input wire logic [3:0] pwm_edge_nominal_in,
   output logic [3:0] pwm_edge_out,
   output logic offsets_active_out
);
   // software registers
   adto_byte_t threshold;        // [2:0] threshold code, [7:3] spare r/w
   adto_byte_t edges_one_two;    // edge one upper nibble, edge two lower
   adto_byte_t edges_three_four; // edge three upper nibble, edge four lower
   adto_range_e sense_range;     // nominal sense range
   logic apply_active;           // gate: offsets in force
   logic [31:0] readdata;        // registered read answer
   logic waitrequest;            // registered wait request

   // bus decode
   wire logic bus_req = avs_read_in || avs_write_in;
   wire logic [7:0] bus_idx = avs_address_in[9:2];
   wire logic bus_done = bus_req && !waitrequest;   // the edge the master sees its answer
   wire logic wr_lane = bus_done && avs_write_in && avs_byteenable_in[0];
   wire logic wr_threshold = wr_lane && bus_idx == `ADTO_IDX_THRESHOLD;
   wire logic wr_one_two = wr_lane && bus_idx == `ADTO_IDX_EDGES_ONE_TWO;
   wire logic wr_three_four = wr_lane && bus_idx == `ADTO_IDX_EDGES_THREE_FOUR;
   wire logic wr_range = wr_lane && bus_idx == `ADTO_IDX_SENSE_RANGE;

   // read mux; unmapped indices read zero
   wire logic [7:0] status_byte = 8'({apply_active});
   wire logic [7:0] rd_byte =
      bus_idx == `ADTO_IDX_THRESHOLD ? threshold :
      bus_idx == `ADTO_IDX_EDGES_ONE_TWO ? edges_one_two :
      bus_idx == `ADTO_IDX_EDGES_THREE_FOUR ? edges_three_four :
      bus_idx == `ADTO_IDX_SENSE_RANGE ? 8'(sense_range) :
      bus_idx == `ADTO_IDX_STATUS ? status_byte : 8'h00;

   // threshold step follows the nominal sense range [R7]
   wire logic [7:0] thresh_lsb =
      sense_range == ADTO_RANGE_LOW ? `ADTO_LSB_RANGE_LOW :
      sense_range == ADTO_RANGE_MID ? `ADTO_LSB_RANGE_MID : `ADTO_LSB_RANGE_HIGH;
   // code zero yields zero, so offsets never apply then [R7]
   // both factors widened first: an 8-bit product would lose the top of 7 x 156
   wire logic [11:0] thresh_level =
      12'(threshold[`ADTO_THRESH_HI:`ADTO_THRESH_LO]) * 12'(thresh_lsb);
   // offsets only below the threshold [R6]
   wire logic next_apply = secondary_current_sense_in < thresh_level;

   // field split per edge: upper nibble for even edges, lower for odd
   logic [3:0] edge_sign;
   adto_shift_t edge_shift [4];
   assign edge_sign[0] = edges_one_two[`ADTO_UPPER_SIGN_BIT];                               // [R1]
   assign edge_shift[0] = edges_one_two[`ADTO_UPPER_SHIFT_HI:`ADTO_UPPER_SHIFT_LO];         // [R2]
   assign edge_sign[1] = edges_one_two[`ADTO_LOWER_SIGN_BIT];                               // [R1]
   assign edge_shift[1] = edges_one_two[`ADTO_LOWER_SHIFT_HI:`ADTO_LOWER_SHIFT_LO];         // [R3]
   assign edge_sign[2] = edges_three_four[`ADTO_UPPER_SIGN_BIT];                            // [R1]
   assign edge_shift[2] = edges_three_four[`ADTO_UPPER_SHIFT_HI:`ADTO_UPPER_SHIFT_LO];      // [R4]
   assign edge_sign[3] = edges_three_four[`ADTO_LOWER_SIGN_BIT];                            // [R1]
   assign edge_shift[3] = edges_three_four[`ADTO_LOWER_SHIFT_HI:`ADTO_LOWER_SHIFT_LO];      // [R5]

   // one shifter per edge, joined through the carrier interface
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         adto_edge_if edge_bus ();
         assign edge_bus.sign = edge_sign[gi];
         assign edge_bus.shift = edge_shift[gi];
         assign edge_bus.apply = apply_active;
         assign edge_bus.nominal = pwm_edge_nominal_in[gi];
         assign pwm_edge_out[gi] = edge_bus.shifted;   // flop inside the shifter
         adto_edge_shift u_shift (
            .sys_clk_in(sys_clk_in),
            .sys_rst_in(sys_rst_in),
            .edge_io(edge_bus.shifter)
         );
      end
   endgenerate

   assign avs_readdata_out = readdata;
   assign avs_waitrequest_out = waitrequest;
   assign offsets_active_out = apply_active;

   // bus handshake: one wait cycle, then a one-cycle answer
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         waitrequest <= 1'b1;
         readdata <= '0;
      end else begin
         waitrequest <= !(bus_req && waitrequest);
         if (bus_req && waitrequest) begin
            readdata <= 32'(rd_byte);
         end
      end
   end

   // register writes take effect only at the answering edge
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         threshold <= `ADTO_RST_BYTE;
         edges_one_two <= `ADTO_RST_BYTE;
         edges_three_four <= `ADTO_RST_BYTE;
         sense_range <= adto_range_e'(`ADTO_RST_RANGE);
      end else begin
         if (wr_threshold) threshold <= avs_writedata_in[7:0];
         if (wr_one_two) edges_one_two <= avs_writedata_in[7:0];
         if (wr_three_four) edges_three_four <= avs_writedata_in[7:0];
         if (wr_range) sense_range <= adto_range_e'(avs_writedata_in[`ADTO_RANGE_HI:`ADTO_RANGE_LO]);
      end
   end

   // threshold gate, registered so the edges see a clean level [R6]
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         apply_active <= 1'b0;
      end else begin
         apply_active <= next_apply;
      end
   end

   // bus answers come one cycle after a fresh request and stand one cycle
   wait_one_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      bus_req && waitrequest |=> !waitrequest)
      else $error("slave did not answer one cycle after request");
   wait_release_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !waitrequest |=> waitrequest)
      else $error("answer stood longer than one cycle");
   // the gate follows the sensed current one cycle later
   above_gate_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R6]
      secondary_current_sense_in >= thresh_level |=> !offsets_active_out)
      else $error("offsets active at or above threshold");
   zero_code_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R7]
      threshold[2:0] == 3'h0 |=> !offsets_active_out)
      else $error("zero threshold code let offsets apply");
   // per-edge latency: nominal edges show nine cycles late, plus or minus the code
   edge_two_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R3]
      edges_one_two[3:0] == 4'h7 && apply_active && pwm_edge_nominal_in[1] |-> ##16 pwm_edge_out[1])
      else $error("edge two not delayed by 35 ns");
   edge_three_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R4]
      edges_three_four[7:4] == 4'ha && apply_active && pwm_edge_nominal_in[2] |-> ##7 pwm_edge_out[2])
      else $error("edge three not advanced by 10 ns");
   edge_four_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R5]
      edges_three_four[3:0] == 4'h5 && apply_active && pwm_edge_nominal_in[3] |-> ##14 pwm_edge_out[3])
      else $error("edge four not delayed by 25 ns");
   // edge one advanced by three steps lands three cycles before the nominal slot
   edge_one_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R1]
      edges_one_two[7:4] == 4'hb && apply_active && pwm_edge_nominal_in[0] |-> ##6 pwm_edge_out[0])
      else $error("edge one not advanced by 15 ns");
   // with the gate off a signed code must not move the edge
   gate_off_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R6]
      !apply_active && pwm_edge_nominal_in[1] |-> ##9 pwm_edge_out[1])
      else $error("edge two moved while offsets were off");

   // bus handshake steps, used to build the answer property
   sequence bus_fresh_s;
      bus_req && waitrequest;
   endsequence
   sequence bus_answer_s;
      !waitrequest ##1 waitrequest;
   endsequence
   bus_handshake_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      bus_fresh_s |=> bus_answer_s)
      else $error("answer did not stand for exactly one cycle");
   // readback of the first edge byte returns the stored signs and codes
   edge_readback_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R1]
      bus_req && waitrequest && avs_read_in && bus_idx == `ADTO_IDX_EDGES_ONE_TWO
      |=> avs_readdata_out == 32'(edges_one_two))
      else $error("edge byte read back wrong");
   // status bit reports the gate as it stood when the read was taken
   status_readback_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R6]
      bus_req && waitrequest && avs_read_in && bus_idx == `ADTO_IDX_STATUS
      |=> avs_readdata_out[`ADTO_STATUS_ACTIVE_BIT] == $past(apply_active))
      else $error("status byte did not report the offset gate");
   // one register per word: the upper lanes always read zero
   upper_zero_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !waitrequest |-> avs_readdata_out[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   // below the threshold the offsets must come into force
   below_gate_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R6]
      secondary_current_sense_in < thresh_level |=> offsets_active_out)
      else $error("offsets inactive below threshold");
   // the spare range code behaves as the widest range
   spare_range_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R7]
      sense_range == ADTO_RANGE_SPARE |-> thresh_lsb == `ADTO_LSB_RANGE_HIGH)
      else $error("spare range did not use the widest step");
   // seven steps of 3.9 mV is 273 tenths of a mV
   top_code_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [R7]
      threshold[2:0] == 3'h7 && sense_range == ADTO_RANGE_LOW |-> thresh_level == 12'h111)
      else $error("top threshold code scaled wrongly");
endmodule

//--- dv/adto_stage_model.sv
// power stage side: sense level and nominal edge pulses, edge timing readback
module adto_stage_model
   import adto_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [3:0] pwm_edge_in,
   output logic [3:0] nominal_out,
   output adto_sense_t sense_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      nominal_out = 4'h0;
      sense_out = 12'h000;
   end
   // new sense level, applied just after an edge
   task automatic set_sense(input adto_sense_t v);
      @(posedge sys_clk_in);
      sense_out <= v;
   endtask
   // one-cycle nominal pulse, then cycles until the shifted edge shows
   // sampled on the falling edge so the registered output has settled
   task automatic fire(input int b, output int lat);
      lat = 0;
      @(posedge sys_clk_in);
      nominal_out[b] <= 1'b1;
      @(posedge sys_clk_in);
      nominal_out[b] <= 1'b0;
      while (lat < 40 && pwm_edge_in[b] !== 1'b1) begin
         @(negedge sys_clk_in);
         lat++;
      end
   endtask
endmodule

//--- dv/tb_top.sv
// bench for the edge offset block
module tb_top;
   import adto_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [9:0] addr = 10'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdata;
   logic wait_r;
   logic [3:0] nom;
   logic [3:0] edge_o;
   logic act;
   adto_sense_t sense;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #2.5 sys_clk_in = ~sys_clk_in;
   adto_top u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .secondary_current_sense_in(sense),
      .pwm_edge_nominal_in(nom), .pwm_edge_out(edge_o), .offsets_active_out(act));
   adto_stage_model u_part (.sys_clk_in(sys_clk_in), .pwm_edge_in(edge_o), .nominal_out(nom),
      .sense_out(sense));
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] b,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      addr <= a;
      wdata <= {24'h0, d};
      be <= b;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (wait_r !== 1'b0 && n < 50);
      if (wait_r !== 1'b0) begin
         bad_count++;
         $display("Error at %0t: no answer on the register bus", $time);
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr8(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'h0, q);
      check(q, exp);
   endtask
   // reset values, storage, byte enable and unmapped place
   task automatic t_regs();
      logic [31:0] q;
      rd_chk(10'h1a4, 32'h0);
      rd_chk(10'h1a8, 32'h0);
      rd_chk(10'h1c4, 32'h0);
      wr8(10'h1a4, 8'ha5);
      rd_chk(10'h1a4, 32'ha5);
      bus(1'b1, 10'h1a8, 8'h77, 4'h0, q); // byte lane off: ignored
      rd_chk(10'h1a8, 32'h0);
      wr8(10'h1a8, 8'h5a);
      rd_chk(10'h1a8, 32'h5a);
      wr8(10'h3fc, 8'hff);
      rd_chk(10'h3fc, 32'h0);
   endtask
   // gate boundaries: {range, code, sense, expected active}
   task automatic t_gate();
      logic [23:0] tab[9] = '{24'h0_1_026_1, 24'h0_1_027_0, 24'h2_1_09b_1,
         24'h2_1_09c_0, 24'h1_0_000_0, 24'h1_2_09b_1, 24'h0_7_110_1,
         24'h3_7_443_1, 24'h3_7_444_0};
      foreach (tab[i]) begin
         wr8(10'h1c0, {4'h0, tab[i][23:20]});
         wr8(10'h1a0, {4'hf, tab[i][19:16]});
         u_part.set_sense(tab[i][15:4]);
         repeat (3) @(posedge sys_clk_in);
         check(act, tab[i][0]);
         rd_chk(10'h1c4, {31'h0, tab[i][0]});
      end
   endtask
   // every edge, sign and code with offsets applied
   task automatic t_edges();
      int lat;
      logic [7:0] v;
      wr8(10'h1c0, 8'h02);
      wr8(10'h1a0, 8'h07);
      u_part.set_sense(12'h000);
      for (int e = 0; e < 4; e++)
         for (int s = 0; s < 2; s++)
            for (int c = 0; c < 8; c++) begin
               v = e[0] ? {4'h0, s[0], c[2:0]} : {s[0], c[2:0], 4'h0};
               wr8(e < 2 ? 10'h1a4 : 10'h1a8, v);
               u_part.fire(e, lat);
               check(lat, s ? 9 - c : 9 + c);
            end
   endtask
   // sense above threshold: both signs keep nominal timing
   task automatic t_nominal();
      int lat;
      u_part.set_sense(12'hfff);
      repeat (3) @(posedge sys_clk_in);
      wr8(10'h1a4, 8'h0d);
      u_part.fire(1, lat);
      check(lat, 9);
      wr8(10'h1a4, 8'h50);
      u_part.fire(0, lat);
      check(lat, 9);
   endtask
   // hang guard, well above the roughly 1100 cycles needed
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_gate();
      t_edges();
      t_nominal();
      test_done();
   end
endmodule
